// ---- core/dacc_pkg.sv ----
package dacc_pkg;

  // ****************************************
  // Bus and data widths
  // ****************************************
  localparam int ADDR_W = 8;   // Byte address width
  localparam int DATA_W = 32;  // APB data width
  localparam int CODE_W = 10;  // Converter code width
  localparam int NINT   = 5;   // Interrupt sources
  localparam int DIV_W  = 11;  // Divider counter width

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BCFG   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ADATA  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_BDATA  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ISR    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IMR    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRSR   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ICR    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_RATE   = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_SRST   = 8'h2C;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  // Channel B configuration, bit 12 down to bit 0
  typedef struct packed {
    logic [1:0] rsv;        // Bits 12:11, keep at three
    logic [1:0] wave;       // Bits 10:9
    logic       time_mode;  // Bit 8
    logic       den;        // Bit 7
    logic [1:0] trig_typ;   // Bits 6:5
    logic [1:0] trig_sel;   // Bits 4:3
    logic       trig_en;    // Bit 2
    logic       io_en;      // Bit 1
    logic       en;         // Bit 0
  } dacc_bcfg_t;
  localparam int BCFG_W = $bits(dacc_bcfg_t);
  localparam logic [12:0] BCFG_RST = 13'h1838;

  // Per-channel control as the channel logic sees it
  typedef struct packed {
    logic       time_mode;
    logic       den;
    logic [1:0] trig_typ;
    logic [1:0] trig_sel;
    logic       trig_en;
    logic       io_en;
    logic       en;
  } dacc_chcfg_t;

  localparam logic [1:0] WAVE_DIFF = 2'h3;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;

  localparam logic [NINT-1:0] IMR_RST = 5'h1F;
  localparam int INT_A_RDY = 0;
  localparam int INT_B_RDY = 1;
  localparam int INT_A_TO  = 2;
  localparam int INT_B_TO  = 3;
  localparam int INT_TRI   = 4;

  // Rate register: bit 4 divider reset, bits 2:1 rate
  localparam int RATE_W       = 5;
  localparam int RATE_SRST    = 4;
  localparam int RATE_SEL_LSB = 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int RATE_SLOW_HZ = 62_500;
  localparam int DIV_SLOW     = CLK_HZ / RATE_SLOW_HZ;

  // Cycles per conversion for a rate code, halved per step
  function automatic logic [DIV_W-1:0] dacc_div(input logic [1:0] sel);
    dacc_div = DIV_W'(DIV_SLOW >> sel);
  endfunction

endpackage

// ---- core/dacc_ctrl.sv ----
module dacc_ctrl
  import dacc_pkg::*;
#(
  parameter int TIMEOUT_CYC = 1000  // Cycles a DMA request may wait
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ADDR_W-1:0]             paddr,
  input  wire logic [DATA_W-1:0]             pwdata,
  output logic      [DATA_W-1:0]             prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire dacc_chcfg_t                   a_cfg,
  input  wire logic [3:0]                    ext_trig,
  input  wire logic                          tria_ovfl_evt,
  output logic      [1:0][CODE_W-1:0]        dac_code,
  output logic      [1:0]                    conv_strobe,
  output logic      [1:0][CODE_W-1:0]        pad_code,
  output logic      [1:0]                    pad_en,
  output logic      [1:0]                    dma_req,
  output logic                               diff_mode,
  output logic                               irq
);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin : g_chk
    $error("TIMEOUT_CYC must lie in 1..65535");
  end

  // ****************************************
  // Register state
  // ****************************************
  dacc_bcfg_t            bcfg_ff;     // Channel B configuration
  logic [1:0][CODE_W-1:0] data_ff;    // Channel data codes
  logic [NINT-1:0]       imr_ff;      // Interrupt mask
  logic [NINT-1:0]       raw_ff;      // Raw interrupt flags
  logic [RATE_W-1:0]     rate_ff;     // Rate and divider reset
  logic [1:0]            srst_ff;     // Channel soft resets
  logic [DATA_W-1:0]     prdata_ff;   // Read data, caught in setup
  logic                  pslverr_ff;  // Unmapped address flag
  logic                  irq_ff;      // Masked interrupt summary

  // ****************************************
  // APB decode
  // ****************************************
  wire setup = psel & ~penable;
  wire wr    = psel & penable & pwrite;
  wire hit_bcfg  = (paddr == OFS_BCFG);
  wire hit_adata = (paddr == OFS_ADATA);
  wire hit_bdata = (paddr == OFS_BDATA);
  wire hit_imr   = (paddr == OFS_IMR);
  wire hit_icr   = (paddr == OFS_ICR);
  wire hit_rate  = (paddr == OFS_RATE);
  wire hit_srst  = (paddr == OFS_SRST);
  wire hit_any   = hit_bcfg | hit_adata | hit_bdata | hit_imr | hit_icr
                 | hit_rate | hit_srst | (paddr == OFS_STATUS)
                 | (paddr == OFS_ISR) | (paddr == OFS_IRSR);
  wire [1:0] wr_data = {wr & hit_bdata, wr & hit_adata};

  // Zero wait states: every access ends in its first access cycle
  assign pready  = psel & penable;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff & pready;

  // ****************************************
  // Channel status wires
  // ****************************************
  logic [1:0]      done_ff;   // Conversion-complete status
  logic [1:0]      start;     // Conversion start this cycle
  logic [1:0]      to_evt;    // DMA wait timed out
  wire  [NINT-1:0] masked = raw_ff & ~imr_ff;

  // Read mux, bits above each field read as zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (paddr)
      OFS_STATUS: rd_mux = DATA_W'(done_ff);
      OFS_BCFG:   rd_mux = DATA_W'(bcfg_ff);
      OFS_ADATA:  rd_mux = DATA_W'(data_ff[0]);
      OFS_BDATA:  rd_mux = DATA_W'(data_ff[1]);
      OFS_ISR:    rd_mux = DATA_W'(masked);
      OFS_IMR:    rd_mux = DATA_W'(imr_ff);
      OFS_IRSR:   rd_mux = DATA_W'(raw_ff);
      OFS_RATE:   rd_mux = DATA_W'(rate_ff);
      OFS_SRST:   rd_mux = DATA_W'(srst_ff);
      default:    rd_mux = '0;                         // Clear reg reads zero
    endcase
  end

  // Read data and error are caught in the setup cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else if (ce && setup) begin
      prdata_ff  <= pwrite ? '0 : rd_mux;
      pslverr_ff <= ~hit_any;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Bits above each field width are dropped from every write; BCFG bits 12:11 are stored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bcfg_ff <= dacc_bcfg_t'(BCFG_RST);
      imr_ff  <= IMR_RST;
      rate_ff <= '0;
      srst_ff <= '0;
    end else if (ce && wr) begin
      if (hit_bcfg) bcfg_ff <= dacc_bcfg_t'(pwdata[BCFG_W-1:0]);
      if (hit_imr)  imr_ff  <= pwdata[NINT-1:0];
      if (hit_rate) rate_ff <= pwdata[RATE_W-1:0];
      if (hit_srst) srst_ff <= pwdata[1:0];
    end
  end

  // Data codes; a channel soft reset clears its own code
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_ff <= '0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (srst_ff[i]) data_ff[i] <= '0;
        else if (wr_data[i]) data_ff[i] <= pwdata[CODE_W-1:0];
      end
    end
  end

  // ****************************************
  // Interrupt flags
  // ****************************************
  wire [NINT-1:0] clr = (wr && hit_icr) ? pwdata[NINT-1:0] : '0;
  wire [NINT-1:0] evt = {tria_ovfl_evt, to_evt, start};

  // A set arriving with its clear wins, so no event is lost
  always_ff @(posedge clk) begin
    if (!nrst) begin
      raw_ff <= '0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      raw_ff <= (raw_ff & ~clr) | evt;
      irq_ff <= |masked;
    end
  end
  assign irq = irq_ff;

  // ****************************************
  // Conversion-rate divider
  // ****************************************
  logic [DIV_W-1:0] div_ff;   // Counts down to the next rate tick
  wire              div_srst = rate_ff[RATE_SRST];
  wire              tick     = (div_ff == '0) & ~div_srst;

  // Held at its reload value while the divider reset bit is set
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_ff <= '0;
    end else if (ce) begin
      if (div_srst || tick) begin
        div_ff <= dacc_div(rate_ff[RATE_SEL_LSB +: 2]) - 1'b1;
      end else begin
        div_ff <= div_ff - 1'b1;
      end
    end
  end

  // ****************************************
  // Channel control
  // ****************************************
  dacc_chcfg_t [1:0] cfg;     // Index 0 channel A, 1 channel B
  assign cfg[0] = a_cfg;
  assign cfg[1] = '{time_mode: bcfg_ff.time_mode, den: bcfg_ff.den,
                    trig_typ: bcfg_ff.trig_typ, trig_sel: bcfg_ff.trig_sel,
                    trig_en: bcfg_ff.trig_en, io_en: bcfg_ff.io_en,
                    en: bcfg_ff.en};
  assign diff_mode = (bcfg_ff.wave == WAVE_DIFF);

  logic [1:0] trig_q_ff;      // Selected trigger, previous cycle
  logic [1:0] pend_ff;        // Fresh code not yet converted
  logic [1:0] req_ff;         // DMA request outstanding
  logic [1:0][15:0] to_cnt_ff;// DMA wait counters
  logic [1:0][CODE_W-1:0] code_ff;
  logic [1:0] strobe_ff;
  logic [1:0][CODE_W-1:0] pad_ff;
  logic [1:0] pad_en_ff;
  logic [1:0] trig_now;
  logic [1:0] trig_edge;
  logic [1:0] own_start;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign trig_now[i] = ext_trig[cfg[i].trig_sel];

    // Edge choice; the reserved code never fires
    assign trig_edge[i] =
        ((cfg[i].trig_typ == TRIG_RISE) & trig_now[i] & ~trig_q_ff[i]) |
        ((cfg[i].trig_typ == TRIG_FALL) & ~trig_now[i] & trig_q_ff[i]) |
        ((cfg[i].trig_typ == TRIG_BOTH) & (trig_now[i] ^ trig_q_ff[i]));

    // External event, else rate tick, else a freshly written code
    assign own_start[i] = cfg[i].en & ~srst_ff[i] &
        (cfg[i].trig_en ? trig_edge[i] :
         cfg[i].time_mode ? tick : pend_ff[i]);

    assign to_evt[i] = req_ff[i] & (to_cnt_ff[i] == 16'(TIMEOUT_CYC - 1));
  end

  // In differential mode channel B converts in step with A
  assign start[0] = own_start[0];
  assign start[1] = diff_mode ? own_start[0] & cfg[1].en & ~srst_ff[1]
                              : own_start[1];

  // Code handed to each converter
  wire [CODE_W-1:0] b_next = diff_mode ? ~data_ff[0] : data_ff[1];

  // Trigger history, pending codes and done status
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trig_q_ff <= '0;
      pend_ff   <= '0;
      done_ff   <= '0;
    end else if (ce) begin
      trig_q_ff <= trig_now;
      for (int i = 0; i < 2; i++) begin
        if (srst_ff[i]) begin
          pend_ff[i] <= 1'b0;
          done_ff[i] <= 1'b0;
        end else if (wr_data[i]) begin
          pend_ff[i] <= 1'b1;
          done_ff[i] <= 1'b0;
        end else if (start[i]) begin
          pend_ff[i] <= 1'b0;
          done_ff[i] <= 1'b1;
        end
      end
    end
  end

  // DMA request: raised after a conversion, dropped by the next code
  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_ff    <= '0;
      to_cnt_ff <= '0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (srst_ff[i] || !cfg[i].den || wr_data[i]) begin
          req_ff[i]    <= 1'b0;
          to_cnt_ff[i] <= '0;
        end else if (start[i]) begin
          req_ff[i]    <= 1'b1;
          to_cnt_ff[i] <= '0;
        end else if (req_ff[i]) begin
          to_cnt_ff[i] <= to_evt[i] ? '0 : to_cnt_ff[i] + 1'b1;
        end
      end
    end
  end
  assign dma_req = req_ff;

  // Converter codes, strobes and pad routing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      code_ff   <= '0;
      strobe_ff <= '0;
      pad_ff    <= '0;
      pad_en_ff <= '0;
    end else if (ce) begin
      strobe_ff <= start;
      if (start[0]) code_ff[0] <= data_ff[0];
      if (start[1]) code_ff[1] <= b_next;
      for (int i = 0; i < 2; i++) begin
        pad_en_ff[i] <= cfg[i].io_en;
        pad_ff[i]    <= cfg[i].io_en ? code_ff[i] : '0;
      end
    end
  end
  assign dac_code    = code_ff;
  assign conv_strobe = strobe_ff;
  assign pad_code    = pad_ff;
  assign pad_en      = pad_en_ff;

endmodule

// ---- tb/dacc_sva.sv ----
// ****************************************
// Port checker for the converter control
// ****************************************
module dacc_sva
  import dacc_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic                   ce,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [ADDR_W-1:0]      paddr,
  input wire logic [DATA_W-1:0]      pwdata,
  input wire logic                   pready,
  input wire logic [1:0]             conv_strobe,
  input wire logic [1:0][CODE_W-1:0] dac_code,
  input wire logic [1:0][CODE_W-1:0] pad_code,
  input wire logic [1:0]             pad_en,
  input wire logic [1:0]             dma_req,
  input wire logic                   diff_mode,
  input wire logic                   irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0]       bcfg_ff;  // Shadow of the B configuration
  logic [NINT-1:0]   mask_ff;  // Shadow of the mask
  logic [CODE_W-1:0] bdat_ff;  // Last B code written
  wire               wr_acc = ce && psel && penable && pwrite;

  // Shadows follow bus writes; soft reset wipes the B code
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bcfg_ff <= BCFG_RST;
      mask_ff <= IMR_RST;
      bdat_ff <= '0;
    end else if (wr_acc) begin
      if (paddr == OFS_BCFG) bcfg_ff <= pwdata[12:0];
      if (paddr == OFS_IMR) mask_ff <= pwdata[NINT-1:0];
      if (paddr == OFS_BDATA) bdat_ff <= pwdata[CODE_W-1:0];
      if (paddr == OFS_SRST && pwdata[1]) bdat_ff <= '0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // DMA enable seen low for two samples
  sequence s_den_low;
    !bcfg_ff[7] [*2];
  endsequence

  a_ready_zero_wait: assert property (pready == (psel && penable)) else $error("pready not zero wait");
  a_diff_from_wave: assert property (diff_mode == (bcfg_ff[10:9] == WAVE_DIFF)) else $error("diff mode wrong");
  a_pad_en_copy: assert property (pad_en[1] == $past(bcfg_ff[1])) else $error("pad enable wrong");
  a_pad_zero_off: assert property (!pad_en[1] |-> pad_code[1] == '0) else $error("pad code not zero");
  a_strobe_needs_en: assert property (conv_strobe[1] |-> $past(bcfg_ff[0])) else $error("B converted while off");
  a_code_from_data: assert property (conv_strobe[1] && !diff_mode |-> dac_code[1] == bdat_ff) else $error("B code wrong");
  a_dma_off_quiet: assert property (s_den_low |-> !dma_req[1]) else $error("DMA request while off");
  a_irq_needs_unmask: assert property (irq |-> $past(mask_ff) != 5'h1F) else $error("irq while all masked");
endmodule

bind dacc_ctrl dacc_sva u_dacc_sva (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .conv_strobe(conv_strobe),
  .dac_code(dac_code), .pad_code(pad_code), .pad_en(pad_en), .dma_req(dma_req), .diff_mode(diff_mode),
  .irq(irq));

// ---- tb/dacc_far.sv ----
// ****************************************
// Trigger sources and converter core model
// ****************************************
module dacc_far
  import dacc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [1:0]             conv_strobe,
  input  wire logic [1:0][CODE_W-1:0] dac_code,
  output logic      [3:0]             ext_trig,
  output logic                        tria_ovfl_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned       b_count;  // B conversions seen
  logic [CODE_W-1:0] b_last;   // Last B code taken

  // Quiet sources at time zero
  initial begin
    ext_trig = 4'h0;
    tria_ovfl_evt = 1'b0;
    b_count = 0;
    b_last = '0;
  end

  // Core latches the code on each B strobe
  always @(posedge clk) begin
    if (conv_strobe[1] === 1'b1) begin
      b_count <= b_count + 1;
      b_last <= dac_code[1];
    end
  end

  // One high pulse: a rising then a falling edge, held long enough to be seen
  task automatic pulse(input int sel);
    @(posedge clk);
    ext_trig[sel] <= 1'b1;
    repeat (3) @(posedge clk);
    ext_trig[sel] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Single-cycle overflow event
  task automatic ovfl();
    @(posedge clk);
    tria_ovfl_evt <= 1'b1;
    @(posedge clk);
    tria_ovfl_evt <= 1'b0;
  endtask
endmodule

// ---- tb/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dacc_pkg::*;

  logic                   clk, nrst, psel, penable, pwrite;
  logic [ADDR_W-1:0]      paddr;
  logic [DATA_W-1:0]      pwdata, prdata, rd;
  logic                   pready, pslverr, er, diff_mode, irq, tria;
  logic [3:0]             ext_trig;
  logic [1:0][CODE_W-1:0] dac_code, pad_code;
  logic [1:0]             conv_strobe, pad_en, dma_req;
  int                     errors, checks_done, c;
  wire dacc_chcfg_t       a_cfg = dacc_chcfg_t'(9'h001);  // Channel A on, data-write driven

  dacc_ctrl #(.TIMEOUT_CYC(8)) u_dacc_ctrl (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_cfg(a_cfg), .ext_trig(ext_trig), .tria_ovfl_evt(tria), .dac_code(dac_code), .conv_strobe(conv_strobe),
    .pad_code(pad_code), .pad_en(pad_en), .dma_req(dma_req), .diff_mode(diff_mode), .irq(irq));
  dacc_far u_dacc_far (.clk(clk), .conv_strobe(conv_strobe), .dac_code(dac_code), .ext_trig(ext_trig),
    .tria_ovfl_evt(tria));

  always #5 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // APB transfer; waits on pready, so slave latency is not assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask

  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rchk(OFS_BCFG, 32'h1838);
    rchk(OFS_IMR, 32'h1F);
    rchk(OFS_RATE, 32'h0);
    rchk(OFS_SRST, 32'h0);
    rchk(OFS_BDATA, 32'h0);
    rchk(OFS_IRSR, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    cmp(er, 1'b1);
  endtask

  task automatic t_untimed();
    wr(OFS_BCFG, 32'h1839);
    wr(OFS_BDATA, 32'h2A5);
    repeat (3) @(posedge clk);
    cmp(u_dacc_far.b_last, 32'h2A5);
    rchk(OFS_STATUS, 32'h2);
    rchk(OFS_IRSR, 32'h2);
    rchk(OFS_ISR, 32'h0);
    wr(OFS_IMR, 32'h1D);
    rchk(OFS_ISR, 32'h2);
    repeat (2) @(posedge clk);
    cmp(irq, 1'b1);
    wr(OFS_ICR, 32'h0);
    rchk(OFS_IRSR, 32'h2);
    wr(OFS_ICR, 32'h2);
    rchk(OFS_IRSR, 32'h0);
    wr(OFS_IMR, 32'h1F);
  endtask

  // Each edge kind on its own source; a pulse carries two edges
  task automatic t_trig();
    for (int t = 1; t <= 3; t++) begin
      wr(OFS_BCFG, 32'h1807 | (t << 5) | (t << 3));
      c = u_dacc_far.b_count;
      u_dacc_far.pulse(t);
      cmp(u_dacc_far.b_count - c, (t == 3) ? 2 : 1);
      cmp(pad_code[1], u_dacc_far.b_last);
    end
  endtask

  task automatic t_dma();
    wr(OFS_BCFG, 32'h1881);
    wr(OFS_BDATA, 32'h1);
    repeat (2) @(posedge clk);
    cmp(dma_req[1], 1'b1);
    repeat (12) @(posedge clk);
    rchk(OFS_IRSR, 32'hA);
    wr(OFS_BCFG, 32'h1801);
    // Request drops one edge after the enable is seen low
    repeat (2) @(posedge clk);
    cmp(dma_req[1], 1'b0);
    wr(OFS_ICR, 32'h1F);
    u_dacc_far.ovfl();
    rchk(OFS_IRSR, 32'h10);
    wr(OFS_ICR, 32'h1F);
  endtask

  // Timed mode at every rate, with the divider held first
  task automatic t_rate();
    wr(OFS_BCFG, 32'h1901);
    for (int r = 0; r < 4; r++) begin
      wr(OFS_RATE, 32'h10 | (r << 1));
      // A tick just before the hold may still finish its conversion
      repeat (2) @(posedge clk);
      c = u_dacc_far.b_count;
      repeat (300) @(posedge clk);
      cmp(u_dacc_far.b_count - c, 0);
      wr(OFS_RATE, r << 1);
      c = u_dacc_far.b_count;
      // Ticks come N and 2N cycles after release; the count lags two edges
      repeat (2 * (1600 >> r) + 2) @(posedge clk);
      cmp(u_dacc_far.b_count - c, 2);
    end
    wr(OFS_BCFG, 32'h1801);
  endtask

  task automatic t_srst_diff();
    wr(OFS_SRST, 32'h2);
    rchk(OFS_BDATA, 32'h0);
    rchk(OFS_STATUS, 32'h0);
    wr(OFS_SRST, 32'h0);
    wr(OFS_BCFG, 32'h1E01);
    wr(OFS_ADATA, 32'h155);
    repeat (3) @(posedge clk);
    cmp(u_dacc_far.b_last, 32'h2AA);
    cmp(diff_mode, 1'b1);
    rchk(OFS_ADATA, 32'h155);
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_untimed();
    t_trig();
    t_dma();
    t_rate();
    t_srst_diff();
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule
